// *** src/lcd_ctrl_defs.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the LCD control.
 * Assumes a 20 MHz system clock.
 */
`ifndef LCD_CTRL_DEFS_SVH
`define LCD_CTRL_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_DISPLAY   4'h0
`define OFS_ADDRESS   4'h1
`define OFS_BIAS      4'h2
`define OFS_POWER     4'h3
`define OFS_VPROG     4'h4
`define OFS_TCOMP     4'h5
`define OFS_OTP       4'h6
`define OFS_STATUS    4'h7
`define OFS_TEMP      4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define DISP_ON_BIT      0
`define DISP_ALL_BIT     1
`define DISP_INV_BIT     2
`define DISP_VMIR_BIT    3
`define PWR_PUMP_BIT     0
`define PWR_MULT_LSB     1
`define TC_EN_BIT        12
`define OTP_USE_BIT      15

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define RST_DISPLAY   4'h2
`define RST_XADDR     7'h00
`define RST_YADDR     5'h00
`define RST_BIAS      3'h0
`define RST_VPROG     8'h00
`define RST_CAL       6'h00
`define RST_TEMP      7'h00
`define RST_SLOPES    12'h000
`define RST_TC_EN     1'b1
`define X_MAX         7'h5f
`define Y_TOP         5'h11
`define TD_LIMIT      7'h3f

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ            20000000
`define TEMP_PERIOD_S     10
`define TEMP_PERIOD_CYC   (`TEMP_PERIOD_S * `CLK_HZ)

`endif

// *** src/lcd_ctrl_pkg.sv ***
/*
 * Types shared by the LCD mode and drive-voltage control files.
 * Assumes nothing of its surroundings.
 */
package lcd_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_ALL_ON = 2'b11,
        MODE_INVERSE = 2'b10
    } display_mode_type;

    typedef enum logic [1:0] {
        TEMP_IDLE = 2'b00,
        TEMP_START = 2'b01,
        TEMP_WAIT = 2'b11
    } temp_state_type;
endpackage

// *** src/vop_calc.sv ***
/*
 * Operating-voltage code arithmetic: temperature term from the slope
 * codes and the saturating sum of programmed value, calibration and term.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_defs.svh"
module vop_calc (
    // Operands
    input wire logic [7:0] programmed_voltage_value_i,
    input wire logic [5:0] calibration_offset_i,
    input wire logic [6:0] temperature_code_i,
    input wire logic compensation_enable_i,
    input wire logic [11:0] slopes_i,
    // Result
    output logic [7:0] operating_voltage_code_o,
    output logic [7:0] temperature_term_o
);
    // Multiplier in quarters: 0,1,2,3,4,5,8,12
    function automatic logic [3:0] slope_quarters(input logic [2:0] code);
        case (code)
            3'h6: slope_quarters = 4'h8;
            3'h7: slope_quarters = 4'hc;
            default: slope_quarters = {1'b0, code};
        endcase
    endfunction

    // Signed clamp of a wide sum into 0..255
    function automatic logic [7:0] sat8(input logic signed [11:0] v);
        if (v < 12'sh000) begin
            sat8 = 8'h00;
        end else if (v > 12'sh0ff) begin
            sat8 = 8'hff;
        end else begin
            sat8 = v[7:0];
        end
    endfunction

    logic [5:0] td;
    logic signed [13:0] vt_q4;
    logic signed [11:0] vt;
    logic signed [11:0] stage1;
    logic [7:0] stage1_sat;

    assign td = (temperature_code_i > `TD_LIMIT) ? 6'h3f : temperature_code_i[5:0];

    // Term in quarters, region picked from the top two code bits
    always_comb begin
        case (td[5:4])
            2'h0: vt_q4 = $signed({10'h0, slope_quarters(slopes_i[5:3])}) * 14'sd16
                        + $signed({10'h0, slope_quarters(slopes_i[2:0])})
                        * $signed({8'h0, 6'd16 - td});
            2'h1: vt_q4 = $signed({10'h0, slope_quarters(slopes_i[5:3])})
                        * $signed({8'h0, 6'd32 - td});
            2'h2: vt_q4 = -($signed({10'h0, slope_quarters(slopes_i[8:6])})
                        * $signed({8'h0, td - 6'd32}));
            default: vt_q4 = -($signed({10'h0, slope_quarters(slopes_i[8:6])}) * 14'sd16)
                        + $signed({10'h0, slope_quarters(slopes_i[11:9])})
                        * $signed({8'h0, td - 6'd48});
        endcase
    end

    // Flooring division of the quarter units keeps the term within 8 bits
    assign vt = compensation_enable_i ? 12'(vt_q4 >>> 2) : 12'sh000;
    assign temperature_term_o = vt[7:0];

    // Two clamped adder stages
    assign stage1 = $signed({4'h0, programmed_voltage_value_i})
                    + $signed({{6{calibration_offset_i[5]}}, calibration_offset_i});
    assign stage1_sat = sat8(stage1);
    assign operating_voltage_code_o = sat8($signed({4'h0, stage1_sat}) + vt);
endmodule
`default_nettype wire

// *** src/temp_sampler.sv ***
/*
 * Periodic temperature measurement: starts a conversion at each period end that finds it idle and
 * holds the last 7-bit result.
 * Assumes the sensor answers start with a done pulse; inputs synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_defs.svh"
module temp_sampler
    import lcd_ctrl_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = `TEMP_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Sensor
    input wire logic sense_done_i,
    input wire logic [6:0] sense_value_i,
    output logic sense_start_o,
    // Result
    output logic [6:0] temperature_code_o
);
    temp_state_type state_q;
    logic [27:0] tick_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_q <= 28'h0;
        end else if (tick_q == 28'(PERIOD_CYC - 1)) begin
            tick_q <= 28'h0;
        end else begin
            tick_q <= tick_q + 28'h1;
        end
    end

    // A new period that lands during a conversion is dropped, not queued
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= TEMP_IDLE;
            sense_start_o <= 1'b0;
        end else begin
            sense_start_o <= 1'b0;
            case (state_q)
                TEMP_IDLE: begin
                    if (tick_q == 28'(PERIOD_CYC - 1)) begin
                        state_q <= TEMP_START;
                        sense_start_o <= 1'b1;
                    end
                end
                TEMP_START: state_q <= TEMP_WAIT;
                TEMP_WAIT: begin
                    if (sense_done_i) begin
                        state_q <= TEMP_IDLE;
                    end
                end
                default: state_q <= TEMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temperature_code_o <= `RST_TEMP;
        end else if (state_q == TEMP_WAIT && sense_done_i) begin
            temperature_code_o <= sense_value_i;
        end
    end
endmodule
`default_nettype wire

// *** src/lcd_mode_ctrl.sv ***
/*
 * Mode and drive-voltage control of a grey-scale LCD row/column driver:
 * display and power-down decode, mirroring, RAM address ranges, bias,
 * pump control and operating-voltage code, plus temperature sampling.
 * Assumes a host instruction decoder writing over a plain register port
 * on the same clock; pins and sensor arrive from outside and are synced.
 */
// Chosen here: the address map and the strobed register port.
// Summary of operation
// - Reset gives power-down, default registers, undefined RAM.
// - Power-down grounds all row and column outputs.
// - Power-down stops oscillator, bias and drive generators; drive discharged.
// - Power-down keeps RAM and accepts RAM writes.
// - Power-down exactly when display-on is 0 and all-pixels-on is 1.
// - Mode comes only from display-on, all-pixels-on and inverse bits.
// - All-pixels-on overrides inverse.
// - Mirror 0: column 0 left, writes run left to right.
// - Mirror 1: column 0 right, writes run right to left.
// - Vertical mirror acts at once without rewrite.
// - 5-bit bank address: codes 0-15 direct, one code for bank 16.
// - Column address spans 0 to 95.
// - 3-bit bias select: alpha 0.00 to 1.05 in 0.15 steps.
// - Bias code zero switches off two column buffers.
// - Bias loads from host or one-time storage.
// - Instructions set pump enable, pump factor and programmed voltage.
// - Voltage code is programmed value plus 6-bit calibration plus 8-bit term.
// - Adder stages clamp at 0 and 255.
// - Temperature measured every 10 seconds; 7-bit code readable.
// - Celsius is 1.875 times code minus 40.
// - Codes above 63 count as 63 for the term.
// - Term added only when compensation enable is 1.
// - Reset zeroes programmed value and calibration; temperature code default.
// - Four host-selectable region slopes, defaults from one-time storage; reset here gives zero slopes, loaded from storage only with use_otp_q set.
// - Slope codes give 0, 0.25, 0.5, 0.75, 1, 1.25, 2, 3.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_defs.svh"
module lcd_mode_ctrl #(
    parameter int unsigned TEMP_PERIOD_CYC = `TEMP_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Pins
    input wire logic horizontal_mirror_input_i,
    // One-time storage
    input wire logic otp_refresh_i,
    input wire logic [5:0] otp_calibration_i,
    input wire logic [2:0] otp_bias_i,
    input wire logic [11:0] otp_slopes_i,
    // RAM write address stepping
    input wire logic ram_write_i,
    output logic [6:0] ram_col_o,
    output logic [4:0] ram_bank_o,
    // Display and analog control
    output lcd_ctrl_pkg::display_mode_type display_mode_o,
    output logic outputs_grounded_o,
    output logic power_down_o,
    output logic osc_enable_o,
    output logic bias_enable_o,
    output logic vlcd_gen_enable_o,
    output logic vlcd_discharge_o,
    output logic column_buffers_off_o,
    output logic vertical_mirror_bit_o,
    output logic [2:0] bias_select_o,
    output logic [1:0] pump_mult_o,
    output logic [7:0] operating_voltage_code_o,
    // Temperature sensor
    input wire logic sense_done_i,
    input wire logic [6:0] sense_value_i,
    output logic sense_start_o
);
    import lcd_ctrl_pkg::*;

    // ****************************************************************
    // Reset release and input synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    logic [1:0] mx_sync_q;
    logic [1:0] done_sync_q;
    logic [6:0] tval_meta_q;
    logic [6:0] tval_q;
    logic mx_q;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            mx_sync_q <= 2'b00;
            done_sync_q <= 2'b00;
            tval_meta_q <= 7'h00;
            tval_q <= 7'h00;
        end else begin
            mx_sync_q <= {mx_sync_q[0], horizontal_mirror_input_i};
            done_sync_q <= {done_sync_q[0], sense_done_i};
            tval_meta_q <= sense_value_i;
            tval_q <= tval_meta_q;
        end
    end
    assign mx_q = mx_sync_q[1];

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic display_on_q;
    logic all_pixels_on_bit_q;
    logic inverse_q;
    logic vmirror_q;
    logic pump_on_q;
    logic [1:0] mult_q;
    logic [7:0] programmed_voltage_value_q;
    logic [5:0] calibration_offset_q;
    logic compensation_enable_q;
    logic [11:0] slopes_q;
    logic [2:0] bias_q;
    logic use_otp_q;
    logic [6:0] x_q;
    logic [4:0] y_q;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = reg_wr_i && (a == ofs);
    endfunction

    // Defaults put the device in power-down
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            {inverse_q, all_pixels_on_bit_q, display_on_q} <= 3'(`RST_DISPLAY);
            vmirror_q <= 1'b0;
        end else if (hit(reg_addr_i, `OFS_DISPLAY)) begin
            display_on_q <= reg_wdata_i[`DISP_ON_BIT];
            all_pixels_on_bit_q <= reg_wdata_i[`DISP_ALL_BIT];
            inverse_q <= reg_wdata_i[`DISP_INV_BIT];
            vmirror_q <= reg_wdata_i[`DISP_VMIR_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pump_on_q <= 1'b0;
            mult_q <= 2'b00;
        end else if (hit(reg_addr_i, `OFS_POWER)) begin
            pump_on_q <= reg_wdata_i[`PWR_PUMP_BIT];
            mult_q <= reg_wdata_i[`PWR_MULT_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            programmed_voltage_value_q <= `RST_VPROG;
        end else if (hit(reg_addr_i, `OFS_VPROG)) begin
            programmed_voltage_value_q <= reg_wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            use_otp_q <= 1'b0;
        end else if (hit(reg_addr_i, `OFS_OTP)) begin
            use_otp_q <= reg_wdata_i[`OTP_USE_BIT];
        end
    end

    // Calibration is zero until storage is refreshed
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            calibration_offset_q <= `RST_CAL;
        end else if (otp_refresh_i) begin
            calibration_offset_q <= otp_calibration_i;
        end
    end

    // Host write and storage load share the register; storage wins when enabled
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            bias_q <= `RST_BIAS;
        end else if (otp_refresh_i && use_otp_q) begin
            bias_q <= otp_bias_i;
        end else if (hit(reg_addr_i, `OFS_BIAS)) begin
            bias_q <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            slopes_q <= `RST_SLOPES;
            compensation_enable_q <= `RST_TC_EN;
        end else if (otp_refresh_i && use_otp_q) begin
            slopes_q <= otp_slopes_i;
        end else if (hit(reg_addr_i, `OFS_TCOMP)) begin
            slopes_q <= reg_wdata_i[11:0];
            compensation_enable_q <= reg_wdata_i[`TC_EN_BIT];
        end
    end

    // ****************************************************************
    // RAM address counters
    // ****************************************************************
    // Bank codes 16 to 31 other than the top code are folded onto it
    function automatic logic [4:0] bank_fix(input logic [4:0] y);
        bank_fix = y[4] ? `Y_TOP : y;
    endfunction

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            x_q <= `RST_XADDR;
            y_q <= `RST_YADDR;
        end else if (hit(reg_addr_i, `OFS_ADDRESS)) begin
            x_q <= (reg_wdata_i[6:0] > `X_MAX) ? `X_MAX : reg_wdata_i[6:0];
            y_q <= bank_fix(reg_wdata_i[12:8]);
        end else if (ram_write_i) begin
            // RAM writes continue in power-down
            x_q <= (x_q == `X_MAX) ? 7'h00 : x_q + 7'h01;
        end
    end

    // Mirror only changes where new data lands; old RAM is not moved
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ram_col_o <= `RST_XADDR;
            ram_bank_o <= `RST_YADDR;
        end else begin
            ram_col_o <= mx_q ? `X_MAX - x_q : x_q;
            ram_bank_o <= y_q;
        end
    end

    // ****************************************************************
    // Mode decode and power-down
    // ****************************************************************
    display_mode_type mode_d;
    logic pd_d;
    assign pd_d = !display_on_q && all_pixels_on_bit_q;

    always_comb begin
        case ({display_on_q, all_pixels_on_bit_q, inverse_q})
            3'b100: mode_d = MODE_NORMAL;
            3'b101: mode_d = MODE_INVERSE;
            3'b110, 3'b111: mode_d = MODE_ALL_ON;
            default: mode_d = MODE_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            display_mode_o <= MODE_OFF;
            power_down_o <= 1'b1;
            outputs_grounded_o <= 1'b1;
            osc_enable_o <= 1'b0;
            bias_enable_o <= 1'b0;
            vlcd_gen_enable_o <= 1'b0;
            vlcd_discharge_o <= 1'b1;
            column_buffers_off_o <= 1'b1;
            vertical_mirror_bit_o <= 1'b0;
            bias_select_o <= `RST_BIAS;
            pump_mult_o <= 2'b00;
        end else begin
            display_mode_o <= mode_d;
            power_down_o <= pd_d;
            outputs_grounded_o <= !display_on_q;
            osc_enable_o <= !pd_d;
            bias_enable_o <= !pd_d;
            vlcd_gen_enable_o <= !pd_d && pump_on_q;
            vlcd_discharge_o <= pd_d;
            column_buffers_off_o <= pd_d || (bias_q == 3'h0);
            vertical_mirror_bit_o <= vmirror_q;
            bias_select_o <= bias_q;
            pump_mult_o <= mult_q;
        end
    end

    // ****************************************************************
    // Temperature and operating voltage
    // ****************************************************************
    logic [6:0] temperature_code;
    logic [7:0] vop_d;
    logic [7:0] vt;

    temp_sampler #(
        .PERIOD_CYC(TEMP_PERIOD_CYC)
    ) u_temp (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .sense_done_i(done_sync_q[1]),
        .sense_value_i(tval_q),
        .sense_start_o(sense_start_o),
        .temperature_code_o(temperature_code)
    );

    vop_calc u_vop (
        .programmed_voltage_value_i(programmed_voltage_value_q),
        .calibration_offset_i(calibration_offset_q),
        .temperature_code_i(temperature_code),
        .compensation_enable_i(compensation_enable_q),
        .slopes_i(slopes_q),
        .operating_voltage_code_o(vop_d),
        .temperature_term_o(vt)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            operating_voltage_code_o <= 8'h00;
        end else begin
            operating_voltage_code_o <= vop_d;
        end
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `OFS_DISPLAY: reg_rdata_o <= {12'h000, vmirror_q, inverse_q,
                                              all_pixels_on_bit_q, display_on_q};
                `OFS_ADDRESS: reg_rdata_o <= {3'h0, y_q, 1'b0, x_q};
                `OFS_BIAS: reg_rdata_o <= {13'h0000, bias_q};
                `OFS_POWER: reg_rdata_o <= {13'h0000, mult_q, pump_on_q};
                `OFS_VPROG: reg_rdata_o <= {8'h00, programmed_voltage_value_q};
                `OFS_TCOMP: reg_rdata_o <= {3'h0, compensation_enable_q, slopes_q};
                `OFS_OTP: reg_rdata_o <= {use_otp_q, 9'h000, calibration_offset_q};
                `OFS_STATUS: reg_rdata_o <= {vt, 7'h00, power_down_o};
                `OFS_TEMP: reg_rdata_o <= {9'h000, temperature_code};
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// *** verification/lcd_mode_ctrl_assertions.sv ***
/* Checker of the LCD control block; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module lcd_mode_ctrl_checker
    import lcd_ctrl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [6:0] ram_col_o,
    input wire logic [4:0] ram_bank_o,
    input wire lcd_ctrl_pkg::display_mode_type display_mode_o,
    input wire logic outputs_grounded_o,
    input wire logic power_down_o,
    input wire logic osc_enable_o,
    input wire logic vlcd_gen_enable_o,
    input wire logic vlcd_discharge_o,
    input wire logic column_buffers_off_o,
    input wire logic [2:0] bias_select_o,
    input wire logic sense_start_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_pd_ground: assert property (power_down_o |-> outputs_grounded_o)
        else $error("pd not grounded");
    a_pd_analog: assert property (power_down_o |->
        !osc_enable_o && !vlcd_gen_enable_o && vlcd_discharge_o)
        else $error("pd analog on");
    a_pd_mode: assert property (power_down_o |-> display_mode_o == MODE_OFF)
        else $error("pd mode not off");
    a_mode_live: assert property (display_mode_o != MODE_OFF |->
        !outputs_grounded_o && !power_down_o)
        else $error("mode on but grounded");
    a_buf_off: assert property ((bias_select_o == 3'h0) [*2] |-> column_buffers_off_o)
        else $error("buffers on, bias 0");
    a_buf_on: assert property ((bias_select_o != 3'h0 && !power_down_o) [*2]
        |-> !column_buffers_off_o)
        else $error("buffers off, bias set");
    a_col_range: assert property (ram_col_o <= 7'h5f)
        else $error("column beyond 95");
    a_bank_code: assert property (ram_bank_o <= 5'h0f || ram_bank_o == 5'h11)
        else $error("illegal bank code");
    a_start_gap: assert property (sense_start_o |=> !sense_start_o [*8])
        else $error("restart too soon");
endmodule
bind lcd_mode_ctrl lcd_mode_ctrl_checker chk_i (.*);
`default_nettype wire

// *** verification/temp_sensor_model.sv ***
/* Sensor model: answers a start with a two-cycle done. */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_model (
    input wire logic clk_sys_i,
    input wire logic start_i,
    input wire logic [6:0] level_i,
    output logic done_o,
    output logic [6:0] value_o
);
    logic [3:0] cnt_q = 4'h0;
    always_ff @(posedge clk_sys_i) begin
        if (start_i) cnt_q <= 4'h1;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q + 4'h1;
    end
    // Inverted away from done so stale reads show
    assign value_o = (cnt_q >= 4'h2 && cnt_q <= 4'ha) ? level_i : ~level_i;
    assign done_o = cnt_q == 4'h5 || cnt_q == 4'h6;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
/* Testbench of the LCD control block; uses the sensor model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lcd_ctrl_pkg::*;
    logic clk_sys_i = 0, rst_n_i = 0, wr = 0, rd = 0, hm = 0, otp = 0, rw = 0;
    logic [3:0] a = 4'h0;
    logic [15:0] wd = 16'h0;
    logic [5:0] cal = 6'h0;
    logic [2:0] ob = 3'h0;
    logic [6:0] tv = 7'h0;
    wire [15:0] rdat;
    wire [6:0] col, sv;
    wire [4:0] bank;
    wire [2:0] bs;
    wire [1:0] pm;
    wire [7:0] vop;
    wire gnd, pd, osc, bia, gen, dis, cbo, vm, sd, sst;
    display_mode_type mode;
    int error_cnt = 0, checked = 0, cyc = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    lcd_mode_ctrl #(.TEMP_PERIOD_CYC(50)) lcd_mode_ctrl_i (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .horizontal_mirror_input_i(hm), .otp_refresh_i(otp),
        .otp_calibration_i(cal), .otp_bias_i(ob), .otp_slopes_i(12'h000), .ram_write_i(rw),
        .ram_col_o(col), .ram_bank_o(bank), .display_mode_o(mode), .outputs_grounded_o(gnd),
        .power_down_o(pd), .osc_enable_o(osc), .bias_enable_o(bia), .vlcd_gen_enable_o(gen),
        .vlcd_discharge_o(dis), .column_buffers_off_o(cbo), .vertical_mirror_bit_o(vm),
        .bias_select_o(bs), .pump_mult_o(pm), .operating_voltage_code_o(vop),
        .sense_done_i(sd), .sense_value_i(sv), .sense_start_o(sst));
    temp_sensor_model temp_sensor_model_i (.clk_sys_i(clk_sys_i), .start_i(sst),
        .level_i(tv), .done_o(sd), .value_o(sv));
    task wrap_up;
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up;
        end
    end
    task ck(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task settle;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task wr_reg(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk_sys_i);
        a <= ad; wd <= d; wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        settle;
    endtask
    task rd_ck(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clk_sys_i);
        a <= ad; rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 ck(rdat, e);
    endtask
    task step;
        @(posedge clk_sys_i) rw <= 1'b1;
        @(posedge clk_sys_i) rw <= 1'b0;
        settle;
    endtask
    task otp_ld(input logic [5:0] c, input logic [2:0] b);
        @(posedge clk_sys_i);
        cal <= c; ob <= b; otp <= 1'b1;
        @(posedge clk_sys_i) otp <= 1'b0;
        settle;
    endtask
    task t_reset;
        ck(16'(pd), 16'h1);
        ck(16'(mode), 16'(MODE_OFF));
        rd_ck(4'h0, 16'h0002);
        rd_ck(4'h5, 16'h1000);
        rd_ck(4'h4, 16'h0);
        rd_ck(4'h6, 16'h0);
        rd_ck(4'h8, 16'h0);
        rd_ck(4'hf, 16'h0);
        ck(16'(vop), 16'h0);
    endtask
    task t_modes;
        logic [2:0] m;
        display_mode_type em;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            wr_reg(4'h0, 16'(m));
            em = !m[0] ? MODE_OFF : m[1] ? MODE_ALL_ON : m[2] ? MODE_INVERSE : MODE_NORMAL;
            ck(16'(mode), 16'(em));
            ck(16'(pd), 16'(!m[0] && m[1]));
            ck(16'(gnd), 16'(!m[0]));
            ck(16'({osc, bia, dis}), (!m[0] && m[1]) ? 16'h1 : 16'h6);
        end
    endtask
    task t_mirror;
        wr_reg(4'h0, 16'h0009);
        ck(16'(vm), 16'h1);
        wr_reg(4'h1, 16'h0f05);
        ck(16'(bank), 16'h0f);
        step;
        ck(16'(col), 16'h06);
        wr_reg(4'h1, 16'h1f64);
        ck(16'({bank, col}), 16'({5'h11, 7'h5f}));
        @(posedge clk_sys_i) hm <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        wr_reg(4'h1, 16'h0005);
        ck(16'(col), 16'h5a);
        step;
        ck(16'(col), 16'h59);
    endtask
    task t_bias;
        for (int b = 0; b < 8; b++) begin
            wr_reg(4'h2, 16'(b));
            ck(16'(bs), 16'(b));
            ck(16'(cbo), 16'(b == 0));
        end
        wr_reg(4'h3, 16'h0005);
        ck(16'({gen, pm}), 16'h6);
        wr_reg(4'h6, 16'h8000);
        otp_ld(6'h00, 3'h5);
        ck(16'(bs), 16'h5);
        wr_reg(4'h6, 16'h0000);
    endtask
    task t_vop;
        wr_reg(4'h5, 16'h0000);
        wr_reg(4'h4, 16'h00fa);
        otp_ld(6'h1f, 3'h0);
        ck(16'(vop), 16'h00ff);
        rd_ck(4'h6, 16'h001f);
        wr_reg(4'h4, 16'h000a);
        otp_ld(6'h20, 3'h0);
        ck(16'(vop), 16'h0);
        otp_ld(6'h00, 3'h0);
        wr_reg(4'h4, 16'd100);
        tv <= 7'd16;
        repeat (120) @(posedge clk_sys_i);
        ck(16'(vop), 16'd100);
        rd_ck(4'h8, 16'd16);
        wr_reg(4'h5, 16'h1020);
        ck(16'(vop), 16'd116);
        rd_ck(4'h7, 16'h1000);
        tv <= 7'd70;
        repeat (120) @(posedge clk_sys_i);
        rd_ck(4'h8, 16'd70);
        wr_reg(4'h5, 16'h1800);
        ck(16'(vop), 16'd115);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        t_reset;
        t_modes;
        t_mirror;
        t_bias;
        t_vop;
        wrap_up;
    end
endmodule
`default_nettype wire
